// *** hdl/usb_periph_bus_cfg.sv ***
// Bus configuration, strap capture, suspend, DMA bus and endpoint set of the USB peripheral
`timescale 1ns/10ps

// Function
// - Strap low at power-up selects split bus: muxed 8-bit AD plus DMA bus.
// - Strap high at power-up selects generic mode: shared 16-bit data bus.
// - After power-up the bus layout strap pin drives a task-file address output.
// - Wake-up input high blocks suspend and wakes the device when suspended.
// - Suspend output follows the suspend state to switch external power.
// - DMA data bus stays high-impedance until a write-direction DMA command is written.
// - Control outputs are always actively driven, never high-impedance.
// - Sixteen endpoints kept: two control, fourteen configurable, plus set-up buffer.
// - Generic mode DMA is slave only on the shared data bus.
// - Split mode address pin set by second strap; DMA may act as master.
// - Eight kilobytes of buffer memory shared by all enabled endpoints.
// - Each configurable endpoint has own enable, transfer type and packet size.
// - Configurable endpoints may double buffer; control and set-up are single.
// - Both control endpoints have a fixed 64-byte maximum packet size.
// - Runs from 12 MHz reference multiplied forty times to 480 MHz.
// - High-speed and full-speed supported; speed detected without firmware.
// - First strap high: separate read/write strobes; low: direction plus data strobe.
// - Second strap low: pin latches address; high: pin marks address or data.
module usb_periph_bus_cfg (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Strap pins; layout and style straps two-way after power-up, address phase strap input only
  input  wire logic        bus_layout_strap_in,
  output logic             bus_layout_strap_out,
  output logic             bus_layout_strap_oe_n,
  input  wire logic        strobe_style_strap_in,
  output logic             strobe_style_strap_out,
  output logic             strobe_style_strap_oe_n,
  input  wire logic        address_phase_strap,
  // Processor bus control pins
  input  wire logic        rd_or_dir_pin,
  input  wire logic        data_strobe_low,
  input  wire logic        address_phase_pin,
  output logic             host_read_q,
  output logic             host_write_q,
  output logic             ad_is_address_q,
  // Mode outputs
  output logic             ad_muxed_q,
  output logic             dma_bus_shared_q,
  output logic             dma_master_ok_q,
  // Power and link
  input  wire logic        resume_request_in,
  input  wire logic        hs_detect_in,
  output logic             suspend_out,
  // DMA bus
  input  wire logic [15:0] dma_data_in,
  output logic      [15:0] dma_data_out,
  output logic             dma_data_oe_n,
  output logic             dma_read_strobe_n,
  output logic             dma_write_strobe_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [usb_periph_pkg::PIN_SYNC_W-1:0] sync1_q;
  logic [usb_periph_pkg::PIN_SYNC_W-1:0] sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {dma_data_in, hs_detect_in, address_phase_pin, data_strobe_low,
                  rd_or_dir_pin, resume_request_in, address_phase_strap,
                  strobe_style_strap_in, bus_layout_strap_in};
      sync2_q <= sync1_q;
    end
  end

  logic        layout_s;
  logic        style_s;
  logic        aphase_s;
  logic        wake_s;
  logic        pin_a_s;
  logic        pin_b_s;
  logic        ale_s;
  logic        hs_s;
  logic [15:0] dma_in_s;
  assign {dma_in_s, hs_s, ale_s, pin_b_s, pin_a_s, wake_s, aphase_s, style_s, layout_s} = sync2_q;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Sampled a few cycles after release so the synchronisers hold real pin levels
  logic [1:0]             settle_q;
  logic                   captured_q;
  usb_periph_pkg::strap_s strap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q   <= 2'h0;
      captured_q <= 1'b0;
      strap_q    <= '0;
    end else if (!captured_q) begin
      if (settle_q == usb_periph_pkg::STRAP_SETTLE) begin
        captured_q <= 1'b1;
        strap_q    <= '{split_bus: !layout_s, rd_wr_style: style_s, addr_indicate: aphase_s};
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ad_muxed_q       <= 1'b0;
      dma_bus_shared_q <= 1'b0;
      dma_master_ok_q  <= 1'b0;
    end else begin
      ad_muxed_q       <= captured_q && strap_q.split_bus;
      dma_bus_shared_q <= captured_q && !strap_q.split_bus;
      dma_master_ok_q  <= captured_q && strap_q.split_bus;
    end
  end

  // ----------------------------------------------------------------
  // Processor bus strobe and address decode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_read_q     <= 1'b0;
      host_write_q    <= 1'b0;
      ad_is_address_q <= 1'b0;
    end else if (!captured_q) begin
      host_read_q  <= 1'b0;
      host_write_q <= 1'b0;
    end else begin
      if (strap_q.rd_wr_style) begin
        host_read_q  <= !pin_a_s;
        host_write_q <= !pin_b_s;
      end else begin
        host_read_q  <= !pin_b_s && pin_a_s;
        host_write_q <= !pin_b_s && !pin_a_s;
      end
      if (!strap_q.split_bus) begin
        ad_is_address_q <= 1'b1;
      end else if (!strap_q.addr_indicate) begin
        ad_is_address_q <= ale_s;
      end else begin
        ad_is_address_q <= !ale_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic        susp_req_q;
  logic [1:0]  task_addr_q;
  logic        dma_dir_q;
  logic        dma_cmd_done_q;
  logic [15:0] dma_out_q;
  logic [15:0] dma_in_q;
  logic [15:0] mem_used_q;
  logic        mem_over_q;
  logic        suspend_q;
  logic        dma_busy_q;
  logic        hs_q;
  logic [31:0] rdata_d;
  logic        err_d;
  logic        ep_hit;
  logic [3:0]  ep_idx;
  logic [7:0]  ep_off;
  logic        wr_fire;

  usb_periph_pkg::ep_cfg_s ep_cfg_q [usb_periph_pkg::CFG_EP_COUNT];

  assign ep_off  = paddr[7:0] - usb_periph_pkg::EP_BASE_OFF;
  assign ep_idx  = ep_off[5:2];
  assign ep_hit  = (paddr[31:8] == 24'h000000) && (paddr[7:0] >= usb_periph_pkg::EP_BASE_OFF)
                   && (ep_off[7:2] < 6'(usb_periph_pkg::CFG_EP_COUNT)) && (paddr[1:0] == 2'h0);
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    rdata_d = 32'h00000000;
    err_d   = 1'b0;
    if (ep_hit) begin
      rdata_d = 32'(ep_cfg_q[ep_idx]);
    end else if (paddr[31:8] != 24'h000000) begin
      err_d = 1'b1;
    end else begin
      case (paddr[7:0])
        usb_periph_pkg::CTRL_OFF:     rdata_d = {29'h0, task_addr_q, susp_req_q};
        usb_periph_pkg::STATUS_OFF:   rdata_d = {24'h0, dma_busy_q, mem_over_q, hs_q, suspend_q,
                                                 captured_q, strap_q.addr_indicate,
                                                 strap_q.rd_wr_style, strap_q.split_bus};
        usb_periph_pkg::MEM_USED_OFF: rdata_d = {16'h0, mem_used_q};
        usb_periph_pkg::DMA_CMD_OFF:  rdata_d = {30'h0, dma_cmd_done_q, dma_dir_q};
        usb_periph_pkg::DMA_DATA_OFF: rdata_d = {16'h0, dma_dir_q ? dma_in_q : dma_out_q};
        usb_periph_pkg::CLK_INFO_OFF: rdata_d = {7'h0, usb_periph_pkg::SAMPLE_CLK_MHZ,
                                                 usb_periph_pkg::PLL_MULT,
                                                 usb_periph_pkg::REF_CLK_MHZ};
        usb_periph_pkg::SETUP_EP_OFF: rdata_d = 32'({usb_periph_pkg::SETUP_BUF_SIZE, 1'b0,
                                                      usb_periph_pkg::EP_TYPE_CTRL, 1'b1});
        usb_periph_pkg::CTL_OUT_OFF,
        usb_periph_pkg::CTL_IN_OFF:   rdata_d = 32'({usb_periph_pkg::CTL_EP_SIZE, 1'b0,
                                                      usb_periph_pkg::EP_TYPE_CTRL, 1'b1});
        default:                      err_d   = 1'b1;
      endcase
    end
  end

  // One wait-free access phase: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= err_d;
      prdata  <= pwrite ? 32'h00000000 : rdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_req_q  <= 1'b0;
      task_addr_q <= 2'h0;
    end else if (wr_fire && paddr[7:0] == usb_periph_pkg::CTRL_OFF) begin
      susp_req_q  <= pwdata[usb_periph_pkg::CTRL_SUSP_BIT];
      task_addr_q <= pwdata[usb_periph_pkg::CTRL_TASK_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Endpoint configuration and buffer accounting
  // ----------------------------------------------------------------
  logic [12:0] ep_bytes [usb_periph_pkg::CFG_EP_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < usb_periph_pkg::CFG_EP_COUNT; gi++) begin : g_ep
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ep_cfg_q[gi] <= '0;
        end else if (wr_fire && ep_hit && ep_idx == 4'(gi)) begin
          ep_cfg_q[gi] <= '{max_pkt: pwdata[usb_periph_pkg::EP_MAX_LSB +: 11],
                            dbl_buf: pwdata[usb_periph_pkg::EP_DBL_BIT],
                            ep_type: pwdata[usb_periph_pkg::EP_TYPE_LSB +: 2],
                            enable:  pwdata[usb_periph_pkg::EP_EN_BIT]};
        end
      end
      // Disabled endpoints take no buffer space
      assign ep_bytes[gi] = !ep_cfg_q[gi].enable ? 13'h0000 :
                            ep_cfg_q[gi].dbl_buf ? {1'b0, ep_cfg_q[gi].max_pkt, 1'b0} :
                            {2'h0, ep_cfg_q[gi].max_pkt};
    end
  endgenerate

  logic [15:0] mem_sum;
  always_comb begin
    mem_sum = 16'(usb_periph_pkg::SETUP_BUF_SIZE) + 16'(usb_periph_pkg::CTL_EP_SIZE)
              + 16'(usb_periph_pkg::CTL_EP_SIZE);
    for (int i = 0; i < usb_periph_pkg::CFG_EP_COUNT; i++) begin
      mem_sum = mem_sum + 16'(ep_bytes[i]);
    end
  end

  // Over-allocation is only flagged; firmware must reconfigure before enabling traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_used_q <= 16'h0000;
      mem_over_q <= 1'b0;
    end else begin
      mem_used_q <= mem_sum;
      mem_over_q <= mem_sum > usb_periph_pkg::BUF_MEM_BYTES;
    end
  end

  // ----------------------------------------------------------------
  // Suspend, speed and task-file address pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_q <= 1'b0;
      hs_q      <= 1'b0;
    end else begin
      hs_q <= hs_s;
      if (wake_s) begin
        suspend_q <= 1'b0;
      end else begin
        suspend_q <= susp_req_q && captured_q;
      end
    end
  end

  assign suspend_out = suspend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_layout_strap_oe_n   <= 1'b1;
      strobe_style_strap_oe_n <= 1'b1;
      bus_layout_strap_out    <= 1'b0;
      strobe_style_strap_out  <= 1'b0;
    end else if (captured_q) begin
      bus_layout_strap_oe_n   <= 1'b0;
      strobe_style_strap_oe_n <= 1'b0;
      bus_layout_strap_out    <= task_addr_q[0];
      strobe_style_strap_out  <= task_addr_q[1];
    end
  end

  // ----------------------------------------------------------------
  // DMA command and strobe sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DMA_IDLE, DMA_STROBE, DMA_DONE} dma_state_e;
  dma_state_e dma_state_q;
  logic [3:0] dma_cnt_q;
  logic       dma_go;

  // Generic mode is slave only, so a start there is ignored
  assign dma_go = wr_fire && paddr[7:0] == usb_periph_pkg::DMA_CMD_OFF
                  && pwdata[usb_periph_pkg::DMA_GO_BIT] && dma_master_ok_q
                  && dma_state_q == DMA_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_dir_q      <= 1'b0;
      dma_cmd_done_q <= 1'b0;
      dma_out_q      <= 16'h0000;
    end else begin
      if (wr_fire && paddr[7:0] == usb_periph_pkg::DMA_CMD_OFF) begin
        dma_dir_q      <= pwdata[usb_periph_pkg::DMA_DIR_BIT];
        dma_cmd_done_q <= 1'b1;
      end
      if (wr_fire && paddr[7:0] == usb_periph_pkg::DMA_DATA_OFF) begin
        dma_out_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_state_q        <= DMA_IDLE;
      dma_cnt_q          <= 4'h0;
      dma_busy_q         <= 1'b0;
      dma_in_q           <= 16'h0000;
      dma_read_strobe_n  <= 1'b1;
      dma_write_strobe_n <= 1'b1;
    end else begin
      case (dma_state_q)
        DMA_IDLE: begin
          if (dma_go) begin
            dma_state_q        <= DMA_STROBE;
            dma_busy_q         <= 1'b1;
            dma_cnt_q          <= 4'(usb_periph_pkg::DMA_STROBE_CYC - 1);
            dma_read_strobe_n  <= !pwdata[usb_periph_pkg::DMA_DIR_BIT];
            dma_write_strobe_n <= pwdata[usb_periph_pkg::DMA_DIR_BIT];
          end
        end
        DMA_STROBE: begin
          if (dma_cnt_q == 4'h0) begin
            dma_state_q        <= DMA_DONE;
            dma_read_strobe_n  <= 1'b1;
            dma_write_strobe_n <= 1'b1;
            if (dma_dir_q) begin
              dma_in_q <= dma_in_s;
            end
          end else begin
            dma_cnt_q <= dma_cnt_q - 4'h1;
          end
        end
        DMA_DONE: begin
          dma_state_q <= DMA_IDLE;
          dma_busy_q  <= 1'b0;
        end
        default: dma_state_q <= DMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_data_oe_n <= 1'b1;
      dma_data_out  <= 16'h0000;
    end else begin
      dma_data_oe_n <= !(dma_cmd_done_q && !dma_dir_q);
      dma_data_out  <= dma_out_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SPLIT_MUX: assert property (@(posedge pclk) disable iff (!presetn)
    captured_q && strap_q.split_bus |=> ad_muxed_q && !dma_bus_shared_q)
    else $error("split strap did not give muxed bus");
  AST_GENERIC_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
    captured_q && !strap_q.split_bus |=> dma_bus_shared_q && !ad_muxed_q)
    else $error("generic strap did not give shared bus");
  AST_STRAP_PIN_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(captured_q) |=> !bus_layout_strap_oe_n ##1 !bus_layout_strap_oe_n)
    else $error("strap pin not turned to output");
  AST_WAKE_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    wake_s |=> !suspend_out)
    else $error("suspended while wake-up high");
  AST_SUSPEND_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(suspend_out) |-> $past(susp_req_q) && !$past(wake_s))
    else $error("suspend output rose without cause");
  AST_DMA_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    !dma_cmd_done_q |=> dma_data_oe_n)
    else $error("DMA bus driven before a command");
  AST_SLAVE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    captured_q && !strap_q.split_bus ##2 1'b1 |-> dma_read_strobe_n && dma_write_strobe_n)
    else $error("DMA strobe in generic slave mode");
  AST_STROBE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(dma_write_strobe_n) |-> !dma_write_strobe_n [*3] ##1 dma_write_strobe_n)
    else $error("DMA write strobe length wrong");
  AST_MEM_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    mem_over_q |-> $past(mem_sum) > usb_periph_pkg::BUF_MEM_BYTES)
    else $error("buffer overflow flag without cause");
  AST_RW_STYLE: assert property (@(posedge pclk) disable iff (!presetn)
    captured_q && strap_q.rd_wr_style && !pin_a_s |=> host_read_q)
    else $error("read strobe not decoded");
  AST_ADDR_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    captured_q && strap_q.split_bus && !strap_q.addr_indicate |=> ad_is_address_q == $past(ale_s))
    else $error("address latch pin not followed");

endmodule : usb_periph_bus_cfg

// *** pkg/usb_periph_pkg.sv ***
// Shared constants and carrier types for the USB peripheral bus and endpoint configuration block
package usb_periph_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] STATUS_OFF    = 8'h04;
  localparam logic [7:0] MEM_USED_OFF  = 8'h08;
  localparam logic [7:0] DMA_CMD_OFF   = 8'h0C;
  localparam logic [7:0] DMA_DATA_OFF  = 8'h10;
  localparam logic [7:0] CLK_INFO_OFF  = 8'h14;
  localparam logic [7:0] SETUP_EP_OFF  = 8'h40;
  localparam logic [7:0] CTL_OUT_OFF   = 8'h44;
  localparam logic [7:0] CTL_IN_OFF    = 8'h48;
  localparam logic [7:0] EP_BASE_OFF   = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SUSP_BIT   = 0;
  localparam int CTRL_TASK_LSB   = 1;
  localparam int DMA_DIR_BIT     = 0;
  localparam int DMA_GO_BIT      = 1;
  localparam int EP_EN_BIT       = 0;
  localparam int EP_TYPE_LSB     = 1;
  localparam int EP_DBL_BIT      = 3;
  localparam int EP_MAX_LSB      = 4;

  // ----------------------------------------------------------------
  // Endpoint set and buffer memory
  // ----------------------------------------------------------------
  localparam int          CFG_EP_COUNT   = 14;
  localparam int          TOTAL_EP_COUNT = 16;
  localparam logic [10:0] SETUP_BUF_SIZE = 11'h008;
  localparam logic [10:0] CTL_EP_SIZE    = 11'h040;
  localparam logic [15:0] BUF_MEM_BYTES  = 16'h2000;
  localparam logic [1:0]  EP_TYPE_ISO    = 2'h1;
  localparam logic [1:0]  EP_TYPE_BULK   = 2'h2;
  localparam logic [1:0]  EP_TYPE_INTR   = 2'h3;
  localparam logic [1:0]  EP_TYPE_CTRL   = 2'h0;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int          PCLK_MHZ       = 25;
  localparam logic [7:0]  REF_CLK_MHZ    = 8'h0C;
  localparam logic [7:0]  PLL_MULT       = 8'h28;
  localparam logic [8:0]  SAMPLE_CLK_MHZ = 9'(REF_CLK_MHZ * PLL_MULT);
  localparam int          DMA_STROBE_NS  = 120;
  localparam int          DMA_STROBE_CYC = (DMA_STROBE_NS * PCLK_MHZ + 999) / 1000;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;
  localparam int          PIN_SYNC_W     = 24;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] max_pkt;
    logic        dbl_buf;
    logic [1:0]  ep_type;
    logic        enable;
  } ep_cfg_s;

  typedef struct packed {
    logic split_bus;
    logic rd_wr_style;
    logic addr_indicate;
  } strap_s;

endpackage : usb_periph_pkg

// *** sim/dma_peer.sv ***
// Behavioural DMA peripheral facing the block's DMA bus
`timescale 1ns/10ps
module dma_peer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // DMA bus
  input  wire logic [15:0] bus_out,
  input  wire logic        bus_oe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic      [15:0] bus_in,
  output logic      [15:0] got_q
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD = 16'hA5C3;
  logic [15:0] idle_q;
  // Takes a word only while the block really drives the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) got_q <= 16'h0000;
    else if (!wr_n && !bus_oe_n) got_q <= bus_out;
  end
  // Idle bus toggles so a stale word never passes for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_q <= 16'h0000;
    else idle_q <= ~idle_q;
  end
  // Read answered as soon as the strobe falls, so the synchronisers see it in time
  assign bus_in = rd_n ? idle_q : WORD;
endmodule : dma_peer

// *** sim/usb_periph_bus_cfg_tb.sv ***
// Self-checking bench for the USB peripheral bus configuration block
`timescale 1ns/10ps
module usb_periph_bus_cfg_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, layout, style;
  logic [31:0] paddr, pwdata, prdata, rd, v;
  logic        address_phase_strap, rd_or_dir_pin, data_strobe_low, address_phase_pin;
  logic        resume_request_in, hs_detect_in, suspend_out, host_read_q, host_write_q;
  logic        bus_layout_strap_out, bus_layout_strap_oe_n, ad_is_address_q, ad_muxed_q;
  logic        strobe_style_strap_out, strobe_style_strap_oe_n, dma_bus_shared_q;
  logic        dma_master_ok_q, dma_data_oe_n, dma_read_strobe_n, dma_write_strobe_n;
  logic [15:0] dma_data_out, peer_in, got;
  wire  [15:0] dma_data_in = dma_data_oe_n ? peer_in : dma_data_out;
  wire         bus_layout_strap_in = bus_layout_strap_oe_n ? layout : bus_layout_strap_out;
  wire         strobe_style_strap_in = strobe_style_strap_oe_n ? style : strobe_style_strap_out;
  int          n_mismatch, tests_run;
  typedef struct packed { logic [7:0] a; logic [32:0] x; } row_s;
  row_s rows [7] = '{'{8'h14, 33'h01E0280C}, '{8'h40, 33'h81}, '{8'h44, 33'h401},
    '{8'h48, 33'h401}, '{8'h08, 33'h88}, '{8'h04, 33'h0B}, '{8'h30, 33'h100000000}};
  usb_periph_bus_cfg i_usb_periph_bus_cfg (.*);
  dma_peer i_dma_peer (.pclk(pclk), .presetn(presetn), .bus_out(dma_data_out),
    .bus_oe_n(dma_data_oe_n), .rd_n(dma_read_strobe_n), .wr_n(dma_write_strobe_n),
    .bus_in(peer_in), .got_q(got));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    tests_run++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic close_out(input logic to);
    if (to) n_mismatch++;
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Extra idle edge at the end keeps two transfers from driving psel in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 16) close_out(1'h1);
    @(posedge pclk);
  endtask : apb
  task automatic dma_wait();
    int k;
    k = 0;
    do begin
      apb(1'h0, 8'h04, 32'h0);
      k++;
    end while (rd[7] !== 1'h0 && k < 10);
    if (k >= 10) close_out(1'h1);
  endtask : dma_wait
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, layout, hs_detect_in} = '0;
    {style, address_phase_strap, address_phase_pin, rd_or_dir_pin, data_strobe_low} = 5'h13;
    n_mismatch = 0;
    tests_run = 0;
    resume_request_in = 1'h0; // Kept low through reset
    repeat (10) @(posedge pclk);
    chk(33'({dma_data_oe_n, bus_layout_strap_oe_n}), 33'h3);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(33'({ad_muxed_q, dma_bus_shared_q, dma_master_ok_q}), 33'h5);
    chk(33'({bus_layout_strap_oe_n, strobe_style_strap_oe_n}), 33'h0);
    foreach (rows[i]) begin
      apb(1'h0, rows[i].a, 32'h0);
      chk({err, rd}, rows[i].x);
    end
    apb(1'h1, 8'h00, 32'h2);
    @(posedge pclk);
    chk(33'({bus_layout_strap_out, strobe_style_strap_out}), 33'h2);
    rd_or_dir_pin <= 1'h0;
    address_phase_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    chk(33'({host_read_q, host_write_q, ad_is_address_q}), 33'h5);
    rd_or_dir_pin <= 1'h1;
    for (int t = 1; t < 4; t++) begin
      v = 32'h401 | 32'(t << 1) | ((t == 2) ? 32'h8 : 32'h0);
      apb(1'h1, 8'(8'h80 + 4 * t), v);
      apb(1'h0, 8'(8'h80 + 4 * t), 32'h0);
      chk({err, rd}, {1'h0, v});
    end
    apb(1'h0, 8'h08, 32'h0);
    chk({err, rd}, 33'h188);
    apb(1'h1, 8'h00, 32'h1);
    repeat (4) @(posedge pclk);
    chk(33'(suspend_out), 33'h1);
    resume_request_in <= 1'h1;
    hs_detect_in <= 1'h1;
    repeat (4) @(posedge pclk);
    chk(33'(suspend_out), 33'h0);
    apb(1'h0, 8'h04, 32'h0);
    chk({err, rd}, 33'h2B);
    resume_request_in <= 1'h0;
    apb(1'h1, 8'h0C, 32'h3);
    dma_wait();
    apb(1'h0, 8'h10, 32'h0);
    chk({err, rd}, 33'hA5C3);
    apb(1'h1, 8'h10, 32'h1234);
    chk(33'(dma_data_oe_n), 33'h1);
    apb(1'h1, 8'h0C, 32'h2);
    repeat (2) @(posedge pclk);
    chk(33'({dma_data_oe_n, dma_data_out}), 33'h01234);
    dma_wait();
    chk(33'(got), 33'h1234);
    for (int t = 4; t < 6; t++) apb(1'h1, 8'(8'h80 + 4 * t), 32'h7FF9);
    apb(1'h0, 8'h04, 32'h0);
    chk(33'(rd[6]), 33'h1);
    // Second power-up with the layout strap high and direction-plus-strobe style
    layout <= 1'h1;
    style <= 1'h0;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(33'({ad_muxed_q, dma_bus_shared_q, dma_master_ok_q}), 33'h2);
    {rd_or_dir_pin, data_strobe_low} <= 2'h0;
    repeat (4) @(posedge pclk);
    chk(33'({host_read_q, host_write_q, ad_is_address_q}), 33'h3);
    apb(1'h1, 8'h0C, 32'h2);
    repeat (4) @(posedge pclk);
    chk(33'({dma_write_strobe_n, dma_read_strobe_n}), 33'h3);
    close_out(1'h0);
  end
endmodule : usb_periph_bus_cfg_tb
